//--- cteu_consts.vh
`ifndef CTEU_CONSTS_VH
`define CTEU_CONSTS_VH
// trap cause bit positions in status and enables
`define CTEU_BIT_BREAK      4'h0
`define CTEU_BIT_INTFAULT   4'h1
`define CTEU_BIT_OVERFLOW   4'h2
`define CTEU_BIT_INVALID    4'h3
`define CTEU_BIT_RD_ICPT    4'h4
`define CTEU_BIT_WR_ICPT    4'h5
`define CTEU_BIT_LOCAL_CH   4'h6
`define CTEU_BIT_REMOTE_CH  4'h7
`define CTEU_BIT_TIMER      4'h8
`define CTEU_BIT_TSLICE     4'h9
`define CTEU_BIT_RUN        4'hA
`define CTEU_BIT_SIGNAL     4'hB
`define CTEU_BIT_PREEMPT    4'hC
`define CTEU_BIT_NOWORK     4'hD
`define CTEU_BIT_CAUSE      4'hF
// trap group codes
`define CTEU_GRP_BREAK      2'h0
`define CTEU_GRP_ERRORS     2'h1
`define CTEU_GRP_SYSOPS     2'h2
`define CTEU_GRP_SCHED      2'h3
// cause-to-group map, two bits per cause 0..13
`define CTEU_GROUP_MAP      28'hFFF_FA94
// reset values
`define CTEU_ENABLES_RST    16'h0000
`define CTEU_STATUS_RST     16'h0000
// handler-workspace word that receives the readied process pointer
`define CTEU_SCHED_WS_WORD  32'h0000_0000
`endif

//--- cteu_cause_sel.v
`include "cteu_consts.vh"
// priority encoder: lowest-numbered pending cause wins, group looked up from map
module cteu_cause_sel (
	pending,
	any,
	cause,
	group
);
	input  wire [13:0] pending;
	output reg         any;
	output reg  [3:0]  cause;
	output reg  [1:0]  group;

	integer i;
	reg [27:0] map;

	always @* begin
		map   = `CTEU_GROUP_MAP;
		any   = 1'b0;
		cause = 4'h0;
		group = 2'h0;
		for (i = 13; i >= 0; i = i - 1) begin
			if (pending[i]) begin
				any   = 1'b1;
				cause = i[3:0];
				group = map[2*i +: 2];
			end
		end
	end
endmodule // cteu_cause_sel

//--- cteu_prio_regs.v
`include "cteu_consts.vh"
// per-priority status and enables registers with trap entry/return and mask ops
module cteu_prio_regs (
	clk,
	sys_rst,
	take,
	take_bit,
	take_cause,
	handler_mask,
	handler_status,
	ret,
	ret_status,
	ret_enables,
	mask_set,
	mask_clr,
	mask_val,
	status_reg,
	enables_reg
);
	input  wire        clk;
	input  wire        sys_rst;
	input  wire        take;
	input  wire [15:0] take_bit;
	input  wire        take_cause;
	input  wire [15:0] handler_mask;
	input  wire [15:0] handler_status;
	input  wire        ret;
	input  wire [15:0] ret_status;
	input  wire [15:0] ret_enables;
	input  wire        mask_set;
	input  wire        mask_clr;
	input  wire [15:0] mask_val;
	output reg  [15:0] status_reg;
	output reg  [15:0] enables_reg;

	reg [15:0] status_next;
	reg [15:0] enables_next;

	always @* begin
		status_next  = status_reg;
		enables_next = enables_reg;
		if (ret) begin
			status_next  = ret_status & ~take_bit;
			enables_next = ret_enables;
		end
		if (mask_set)
			enables_next = enables_next | mask_val;
		if (mask_clr)
			enables_next = enables_next & ~mask_val;
		if (take) begin
			status_next  = handler_status;
			status_next  = status_next | take_bit;
			if (take_cause)
				status_next[15] = 1'b1;
			enables_next = enables_reg & handler_mask;
		end
		enables_next[15] = 1'b0;
		enables_next[14] = 1'b0;
	end

	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			status_reg  <= `CTEU_STATUS_RST;
			enables_reg <= `CTEU_ENABLES_RST;
		end else begin
			status_reg  <= status_next;
			enables_reg <= enables_next;
		end
	end
endmodule // cteu_prio_regs

//--- cteu_trap_unit.v
`include "cteu_consts.vh"
module cteu_trap_unit (
	clk,
	sys_rst,
	cfg_halt_on_error,
	sw_error,
	error_clear,
	cur_prio,
	interruptible,
	breakpoint_instr,
	integer_fault,
	overflow,
	invalid_instruction,
	handler_read_intercept,
	handler_write_intercept,
	sched_prio,
	local_channel_sched,
	remote_channel_sched,
	timer_sched,
	timeslice_sched,
	run_sched,
	signal_sched,
	priority_preempt_event,
	no_work_event,
	ready_wptr,
	raise_fault,
	raise_group,
	instruction_pointer,
	workspace_pointer,
	hdl_wr,
	hdl_prio,
	hdl_group,
	hdl_instruction_pointer,
	hdl_wptr,
	hdl_status,
	hdl_enables,
	trap_return,
	mask_set,
	mask_clr,
	mask_prio,
	mask_val,
	error_output_pin,
	cpu_halted,
	trap_taken,
	trap_prio,
	trap_group,
	new_instruction_pointer,
	new_wptr,
	saved_instruction_pointer,
	saved_wptr,
	saved_status,
	saved_enables,
	sched_ws_wr,
	sched_ws_addr,
	sched_ws_data,
	mask_old,
	status_hi,
	status_lo,
	enables_hi,
	enables_lo
);
	input  wire        clk;
	input  wire        sys_rst;
	input  wire        cfg_halt_on_error;
	input  wire        sw_error;
	input  wire        error_clear;
	input  wire        cur_prio;
	input  wire        interruptible;
	input  wire        breakpoint_instr;
	input  wire        integer_fault;
	input  wire        overflow;
	input  wire        invalid_instruction;
	input  wire        handler_read_intercept;
	input  wire        handler_write_intercept;
	input  wire        sched_prio;
	input  wire        local_channel_sched;
	input  wire        remote_channel_sched;
	input  wire        timer_sched;
	input  wire        timeslice_sched;
	input  wire        run_sched;
	input  wire        signal_sched;
	input  wire        priority_preempt_event;
	input  wire        no_work_event;
	input  wire [31:0] ready_wptr;
	input  wire        raise_fault;
	input  wire [1:0]  raise_group;
	input  wire [31:0] instruction_pointer;
	input  wire [31:0] workspace_pointer;
	input  wire        hdl_wr;
	input  wire        hdl_prio;
	input  wire [1:0]  hdl_group;
	input  wire [31:0] hdl_instruction_pointer;
	input  wire [31:0] hdl_wptr;
	input  wire [15:0] hdl_status;
	input  wire [15:0] hdl_enables;
	input  wire        trap_return;
	input  wire        mask_set;
	input  wire        mask_clr;
	input  wire        mask_prio;
	input  wire [15:0] mask_val;
	output wire        error_output_pin;
	output wire        cpu_halted;
	output reg         trap_taken;
	output reg         trap_prio;
	output reg  [1:0]  trap_group;
	output reg  [31:0] new_instruction_pointer;
	output reg  [31:0] new_wptr;
	output reg  [31:0] saved_instruction_pointer;
	output reg  [31:0] saved_wptr;
	output reg  [15:0] saved_status;
	output reg  [15:0] saved_enables;
	output reg         sched_ws_wr;
	output reg  [31:0] sched_ws_addr;
	output reg  [31:0] sched_ws_data;
	output reg  [15:0] mask_old;
	output wire [15:0] status_hi;
	output wire [15:0] status_lo;
	output wire [15:0] enables_hi;
	output wire [15:0] enables_lo;

	localparam ST_RUN  = 2'b01;
	localparam ST_HALT = 2'b10;

	reg        error_reg;
	reg [1:0]  state_reg;
	reg [1:0]  state_next;
	// handler table: index = {prio, group}
	reg [31:0] h_instruction_pointer_mem   [0:7];
	reg [31:0] h_wptr_mem   [0:7];
	reg [15:0] h_status_mem [0:7];
	reg [15:0] h_enables_mem[0:7];
	// trapped process save area per priority
	reg [31:0] t_instruction_pointer_mem   [0:1];
	reg [31:0] t_wptr_mem   [0:1];
	reg [15:0] t_status_mem [0:1];
	reg [15:0] t_enables_mem[0:1];
	reg [15:0] pend_cur;
	reg [15:0] pend_sch;
	reg [15:0] pend_cause;
	reg [15:0] en_cur;
	reg [15:0] en_sch;
	reg [15:0] pend;
	reg        take_prio;
	reg [15:0] pend_sel;
	wire       sel_any;
	wire [3:0] sel_cause;
	wire [1:0] sel_group;
	reg        cause_flag;
	reg [1:0]  grp_fin;
	wire [2:0] hidx;
	reg [15:0] take_bit;
	reg [15:0] ret_bit_lo;
	reg [15:0] ret_bit_hi;
	reg        take_lo;
	reg        take_hi;
	reg [15:0] last_bit_lo;
	reg [15:0] last_bit_hi;
	integer    k;

	assign error_output_pin = error_reg;
	assign cpu_halted       = state_reg[1];

	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst)
			error_reg <= 1'b0;
		else if (sw_error | (overflow & ~en_cur[`CTEU_BIT_OVERFLOW]))
			error_reg <= 1'b1;
		else if (error_clear)
			error_reg <= 1'b0;
	end

	always @* begin
		case (state_reg)
		ST_RUN:  state_next = (error_reg & cfg_halt_on_error) ? ST_HALT : ST_RUN;
		ST_HALT: state_next = error_reg ? ST_HALT : ST_RUN;
		default: state_next = ST_RUN;
		endcase
	end

	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst)
			state_reg <= ST_RUN;
		else
			state_reg <= state_next;
	end

	always @* begin
		en_cur = cur_prio ? enables_lo : enables_hi;
		en_sch = sched_prio ? enables_lo : enables_hi;
		pend_cur = 16'h0000;
		pend_cur[`CTEU_BIT_BREAK]    = breakpoint_instr;
		pend_cur[`CTEU_BIT_INTFAULT] = integer_fault;
		pend_cur[`CTEU_BIT_OVERFLOW] = overflow;
		pend_cur[`CTEU_BIT_INVALID]  = invalid_instruction;
		pend_cur[`CTEU_BIT_RD_ICPT]  = handler_read_intercept;
		pend_cur[`CTEU_BIT_WR_ICPT]  = handler_write_intercept;
		pend_sch = 16'h0000;
		pend_sch[`CTEU_BIT_LOCAL_CH]  = local_channel_sched;
		pend_sch[`CTEU_BIT_REMOTE_CH] = remote_channel_sched;
		pend_sch[`CTEU_BIT_TIMER]     = timer_sched;
		pend_sch[`CTEU_BIT_TSLICE]    = timeslice_sched;
		pend_sch[`CTEU_BIT_RUN]       = run_sched;
		pend_sch[`CTEU_BIT_SIGNAL]    = signal_sched;
		pend_sch[`CTEU_BIT_PREEMPT]   = priority_preempt_event;
		pend_sch[`CTEU_BIT_NOWORK]    = no_work_event;
		// raise-fault sets the lowest enabled cause bit of the chosen group
		pend_cause = 16'h0000;
		for (k = 13; k >= 0; k = k - 1)
			if (((`CTEU_GROUP_MAP >> (2*k)) & 28'h3) == {26'h0, raise_group} && en_cur[k]) begin
				pend_cause = 16'h0000;
				pend_cause[k] = raise_fault;
			end
		// current-process traps take precedence over scheduler ones in the same cycle
		pend_cur = (pend_cur | pend_cause) & en_cur;
		pend_sch = pend_sch & en_sch;
		take_prio = (|pend_cur[13:0]) ? cur_prio : sched_prio;
		pend      = (|pend_cur[13:0]) ? pend_cur : pend_sch;
		pend_sel  = interruptible && state_reg == ST_RUN ? pend : 16'h0000;
		cause_flag = raise_fault && (|pend_cause) && (|pend_cur[13:0]);
	end

	cteu_cause_sel u_sel (
		.pending (pend_sel[13:0]),
		.any     (sel_any),
		.cause   (sel_cause),
		.group   (sel_group)
	);

	assign hidx = {take_prio, grp_fin};

	always @* begin
		grp_fin = cause_flag ? raise_group : sel_group;
		take_bit = 16'h0000;
		take_bit[sel_cause] = sel_any;
		take_hi = sel_any & ~take_prio;
		take_lo = sel_any & take_prio;
		ret_bit_hi = trap_return & ~cur_prio ? last_bit_hi : 16'h0000;
		ret_bit_lo = trap_return & cur_prio ? last_bit_lo : 16'h0000;
	end

	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			trap_taken    <= 1'b0;
			trap_prio     <= 1'b0;
			trap_group    <= 2'h0;
			new_instruction_pointer      <= 32'h0000_0000;
			new_wptr      <= 32'h0000_0000;
			saved_instruction_pointer    <= 32'h0000_0000;
			saved_wptr    <= 32'h0000_0000;
			saved_status  <= 16'h0000;
			saved_enables <= 16'h0000;
			sched_ws_wr   <= 1'b0;
			sched_ws_addr <= 32'h0000_0000;
			sched_ws_data <= 32'h0000_0000;
			mask_old      <= 16'h0000;
			last_bit_hi   <= 16'h0000;
			last_bit_lo   <= 16'h0000;
		end else begin
			trap_taken  <= sel_any;
			sched_ws_wr <= 1'b0;
			if (sel_any) begin
				trap_prio     <= take_prio;
				trap_group    <= grp_fin;
				new_instruction_pointer      <= h_instruction_pointer_mem[hidx];
				new_wptr      <= h_wptr_mem[hidx];
				saved_instruction_pointer    <= instruction_pointer;
				saved_wptr    <= workspace_pointer;
				saved_status  <= take_prio ? status_lo : status_hi;
				saved_enables <= take_prio ? enables_lo : enables_hi;
				if (take_prio)
					last_bit_lo <= take_bit;
				else
					last_bit_hi <= take_bit;
				if (grp_fin == `CTEU_GRP_SCHED && (|pend_sch[11:6]) && ~(|pend_cur[13:0])) begin
					sched_ws_wr   <= 1'b1;
					sched_ws_addr <= h_wptr_mem[hidx] + `CTEU_SCHED_WS_WORD;
					sched_ws_data <= ready_wptr;
				end
			end
			if (mask_set | mask_clr)
				mask_old <= mask_prio ? enables_lo : enables_hi;
		end
	end

	// handler and trapped-process stores are memories with no reset
	always @(posedge clk) begin
		if (hdl_wr) begin
			h_instruction_pointer_mem[{hdl_prio, hdl_group}]    <= hdl_instruction_pointer;
			h_wptr_mem[{hdl_prio, hdl_group}]    <= hdl_wptr;
			h_status_mem[{hdl_prio, hdl_group}]  <= hdl_status;
			h_enables_mem[{hdl_prio, hdl_group}] <= hdl_enables;
		end
		if (sel_any) begin
			t_instruction_pointer_mem[take_prio]    <= instruction_pointer;
			t_wptr_mem[take_prio]    <= workspace_pointer;
			t_status_mem[take_prio]  <= take_prio ? status_lo : status_hi;
			t_enables_mem[take_prio] <= take_prio ? enables_lo : enables_hi;
		end
	end

	cteu_prio_regs u_hi (
		.clk            (clk),
		.sys_rst        (sys_rst),
		.take           (take_hi),
		.take_bit       (take_bit),
		.take_cause     (cause_flag),
		.handler_mask   (h_enables_mem[hidx]),
		.handler_status (h_status_mem[hidx]),
		.ret            (trap_return & ~cur_prio),
		.ret_status     (t_status_mem[0] & ~ret_bit_hi),
		.ret_enables    (t_enables_mem[0]),
		.mask_set       (mask_set & ~mask_prio),
		.mask_clr       (mask_clr & ~mask_prio),
		.mask_val       (mask_val),
		.status_reg     (status_hi),
		.enables_reg    (enables_hi)
	);

	cteu_prio_regs u_lo (
		.clk            (clk),
		.sys_rst        (sys_rst),
		.take           (take_lo),
		.take_bit       (take_bit),
		.take_cause     (cause_flag),
		.handler_mask   (h_enables_mem[hidx]),
		.handler_status (h_status_mem[hidx]),
		.ret            (trap_return & cur_prio),
		.ret_status     (t_status_mem[1] & ~ret_bit_lo),
		.ret_enables    (t_enables_mem[1]),
		.mask_set       (mask_set & mask_prio),
		.mask_clr       (mask_clr & mask_prio),
		.mask_val       (mask_val),
		.status_reg     (status_lo),
		.enables_reg    (enables_lo)
	);
endmodule // cteu_trap_unit

//--- cteu_checker.sv
module cteu_checker (
	input logic        clk,
	input logic        sys_rst,
	input logic        cfg_halt_on_error,
	input logic        sw_error,
	input logic        error_clear,
	input logic        cur_prio,
	input logic        interruptible,
	input logic        breakpoint_instr,
	input logic        integer_fault,
	input logic        overflow,
	input logic [31:0] ready_wptr,
	input logic        mask_set,
	input logic        mask_clr,
	input logic        mask_prio,
	input logic        error_output_pin,
	input logic        cpu_halted,
	input logic        trap_taken,
	input logic        trap_prio,
	input logic [1:0]  trap_group,
	input logic [31:0] new_wptr,
	input logic        sched_ws_wr,
	input logic [31:0] sched_ws_addr,
	input logic [31:0] sched_ws_data,
	input logic [15:0] mask_old,
	input logic [15:0] status_hi,
	input logic [15:0] enables_hi
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);
	// running process at high priority may be trapped this cycle
	sequence s_hi_open;
		interruptible && !cpu_halted && !cur_prio;
	endsequence
	sequence s_brk;
		s_hi_open ##0 breakpoint_instr && enables_hi[0];
	endsequence
	sequence s_ovf;
		s_hi_open ##0 overflow && enables_hi[2] && !breakpoint_instr && !integer_fault;
	endsequence
	chk_brk_group: assert property (s_brk |=> trap_taken && trap_group == 2'h0 && status_hi[0])
		else $error("breakpoint not taken to its group");
	chk_ovf_group: assert property (s_ovf |=> trap_taken && trap_group == 2'h1 && status_hi[2])
		else $error("overflow not taken to the errors group");
	chk_take_gate: assert property (trap_taken |-> $past(interruptible) && !$past(cpu_halted))
		else $error("trap taken while not interruptible or halted");
	chk_err_set: assert property (sw_error |=> error_output_pin)
		else $error("error pin not set by software error");
	chk_err_clear: assert property (error_clear && !sw_error && !overflow |=> !error_output_pin)
		else $error("error pin not cleared");
	chk_halt_on_err: assert property ($rose(error_output_pin) && cfg_halt_on_error |-> ##[0:1] cpu_halted)
		else $error("core did not halt on error");
	chk_ws_write: assert property (sched_ws_wr |-> trap_taken && trap_group == 2'h3
		&& sched_ws_addr == new_wptr && sched_ws_data == $past(ready_wptr))
		else $error("scheduler workspace write wrong");
	chk_mask_old: assert property (mask_set && !mask_prio |=> mask_old == $past(enables_hi))
		else $error("previous mask not returned");
	chk_en_and: assert property (trap_taken && !trap_prio && !$past(mask_set) && !$past(mask_clr)
		|-> (enables_hi & ~$past(enables_hi)) == 16'h0000)
		else $error("enables grew on trap entry");
endmodule // cteu_checker

//--- test_cpu_trap_exception_unit.sv
module test_cpu_trap_exception_unit;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk, sys_rst, cfg_halt_on_error, sw_error, error_clear, cur_prio, interruptible;
	logic        sched_prio, raise_fault, hdl_wr, hdl_prio, trap_return, mask_set, mask_clr, mask_prio;
	logic [13:0] cz;
	logic [1:0]  raise_group, hdl_group, trap_group;
	logic [31:0] ready_wptr, instruction_pointer, workspace_pointer, hdl_instruction_pointer, hdl_wptr;
	logic [15:0] hdl_status, hdl_enables, mask_val;
	logic        error_output_pin, cpu_halted, trap_taken, trap_prio, sched_ws_wr;
	logic [31:0] new_instruction_pointer, new_wptr, saved_instruction_pointer, saved_wptr, sched_ws_addr, sched_ws_data;
	logic [15:0] saved_status, saved_enables, mask_old, status_hi, status_lo, enables_hi, enables_lo;
	int          fail_count = 0, checked = 0, cyc = 0;

	cteu_trap_unit dut_u (
		.breakpoint_instr(cz[0]), .integer_fault(cz[1]), .overflow(cz[2]),
		.invalid_instruction(cz[3]), .handler_read_intercept(cz[4]), .handler_write_intercept(cz[5]),
		.local_channel_sched(cz[6]), .remote_channel_sched(cz[7]), .timer_sched(cz[8]),
		.timeslice_sched(cz[9]), .run_sched(cz[10]), .signal_sched(cz[11]),
		.priority_preempt_event(cz[12]), .no_work_event(cz[13]), .*
	);

	always #2 clk = ~clk;
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			fail_count++;
			finish_test();
		end
	end

	task finish_test;
		$display("checks %0d failures %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task tk;
		@(posedge clk);
		#1;
	endtask

	function automatic logic [1:0] grp(int c);
		return (c == 0) ? 2'h0 : (c < 3) ? 2'h1 : (c < 6) ? 2'h2 : 2'h3;
	endfunction

	function automatic logic [15:0] gmask(int g);
		return (g == 0) ? 16'h0001 : (g == 1) ? 16'h0006 : (g == 2) ? 16'h0038 : 16'h3FC0;
	endfunction

	function automatic logic [15:0] en(int p);
		return p ? enables_lo : enables_hi;
	endfunction

	function automatic logic [15:0] st(int p);
		return p ? status_lo : status_hi;
	endfunction

	// one mask operation, previous mask and new enables checked
	task automatic mop(int p, logic set, logic [15:0] v, logic [15:0] old, logic [15:0] nw);
		mask_prio = p;
		mask_val = v;
		mask_set = set;
		mask_clr = !set;
		tk();
		{mask_set, mask_clr} = 2'h0;
		chk(mask_old, old);
		chk(en(p), nw);
	endtask

	task automatic t_reset_masks;
		for (int p = 0; p < 2; p++) begin
			chk(st(p), 16'h0000);
			chk(en(p), 16'h0000);
			mop(p, 1'h1, 16'h00F0, 16'h0000, 16'h00F0);
			mop(p, 1'h1, 16'hFF3F, 16'h00F0, 16'h3FFF);
			mop(p, 1'h0, 16'h0030, 16'h3FFF, 16'h3FCF);
			mop(p, 1'h1, 16'h0030, 16'h3FCF, 16'h3FFF);
		end
		chk(error_output_pin, 1'h0);
		for (int i = 0; i < 8; i++) begin
			{hdl_prio, hdl_group} = i[2:0];
			hdl_instruction_pointer = 32'h0000_A000 + i;
			hdl_wptr = 32'h0000_B000 + i;
			hdl_enables = 16'h3FFF & ~gmask(i % 4);
			hdl_status = 16'h4000;
			hdl_wr = 1'h1;
			tk();
		end
		hdl_wr = 1'h0;
	endtask

	task automatic t_causes;
		for (int p = 0; p < 2; p++) begin
			for (int c = 0; c < 14; c++) begin
				{cur_prio, sched_prio} = {p[0], p[0]};
				instruction_pointer = 32'h100 + c;
				workspace_pointer = 32'h200 + c;
				ready_wptr = 32'h300 + c;
				cz[c] = 1'h1;
				tk();
				cz = 14'h0000;
				chk(trap_taken, 1'h1);
				chk(trap_prio, p);
				chk(trap_group, grp(c));
				chk(st(p), 16'h4000 | 16'h0001 << c);
				chk(new_instruction_pointer, 32'h0000_A000 + p * 4 + grp(c));
				chk(new_wptr, 32'h0000_B000 + p * 4 + grp(c));
				chk(saved_instruction_pointer, 32'h100 + c);
				chk(saved_wptr, 32'h200 + c);
				chk(saved_status, 16'h0000);
				chk(saved_enables, 16'h3FFF);
				chk(en(p), 16'h3FFF & ~gmask(grp(c)));
				if (c > 5 && c < 12) begin
					chk(sched_ws_wr, 1'h1);
					chk(sched_ws_addr, 32'h0000_B000 + p * 4 + 3);
					chk(sched_ws_data, 32'h300 + c);
				end
				trap_return = 1'h1;
				tk();
				trap_return = 1'h0;
				chk(st(p), 16'h0000);
				chk(en(p), 16'h3FFF);
			end
		end
		{cur_prio, sched_prio} = 2'h0;
	endtask

	task automatic t_refused;
		// current-process causes beat a scheduler event, lowest bit wins
		{cur_prio, sched_prio} = 2'h1;
		cz = 14'h0046;
		tk();
		cz = 14'h0000;
		chk(trap_prio, 1'h0);
		chk(trap_group, 2'h1);
		chk(status_hi, 16'h4002);
		chk(status_lo, 16'h0000);
		trap_return = 1'h1;
		tk();
		trap_return = 1'h0;
		cz[6] = 1'h1;
		tk();
		cz = 14'h0000;
		chk(trap_prio, 1'h1);
		chk(trap_group, 2'h3);
		chk(status_lo, 16'h4040);
		chk(status_hi, 16'h0000);
		chk(sched_ws_wr, 1'h1);
		{cur_prio, trap_return} = 2'h3;
		tk();
		{cur_prio, sched_prio, trap_return} = 3'h0;
		chk(status_lo, 16'h0000);
		chk(enables_lo, 16'h3FFF);
		mop(0, 1'h0, 16'h0004, 16'h3FFF, 16'h3FFB);
		cz[2] = 1'h1;
		tk();
		cz = 14'h0000;
		chk(trap_taken, 1'h0);
		chk(status_hi, 16'h0000);
		chk(error_output_pin, 1'h1);
		error_clear = 1'h1;
		tk();
		error_clear = 1'h0;
		chk(error_output_pin, 1'h0);
		mop(0, 1'h1, 16'h0004, 16'h3FFB, 16'h3FFF);
		interruptible = 1'h0;
		cz[0] = 1'h1;
		tk();
		cz = 14'h0000;
		interruptible = 1'h1;
		chk(trap_taken, 1'h0);
	endtask

	task automatic t_error;
		for (int h = 0; h < 2; h++) begin
			cfg_halt_on_error = h;
			sw_error = 1'h1;
			tk();
			sw_error = 1'h0;
			chk(error_output_pin, 1'h1);
			tk();
			chk(cpu_halted, h);
			cz[0] = 1'h1;
			tk();
			cz = 14'h0000;
			chk(trap_taken, !h);
			if (!h) begin
				trap_return = 1'h1;
				tk();
				trap_return = 1'h0;
			end
			error_clear = 1'h1;
			tk();
			error_clear = 1'h0;
			tk();
			chk(cpu_halted, 1'h0);
			chk(error_output_pin, 1'h0);
		end
		cfg_halt_on_error = 1'h0;
	endtask

	task automatic t_raise;
		for (int g = 0; g < 4; g++) begin
			raise_group = g;
			raise_fault = 1'h1;
			tk();
			raise_fault = 1'h0;
			chk(trap_taken, 1'h1);
			chk(trap_group, g);
			chk(status_hi, 16'hC000 | (gmask(g) & -gmask(g)));
			trap_return = 1'h1;
			tk();
			trap_return = 1'h0;
			chk(status_hi, 16'h0000);
		end
	endtask

	initial begin
		{clk, cfg_halt_on_error, sw_error, error_clear, cur_prio, sched_prio, raise_fault, hdl_wr} = '0;
		{hdl_prio, trap_return, mask_set, mask_clr, mask_prio, cz, raise_group, hdl_group, mask_val} = '0;
		{ready_wptr, instruction_pointer, workspace_pointer, hdl_instruction_pointer, hdl_wptr, hdl_status, hdl_enables} = '0;
		{sys_rst, interruptible} = 2'h3;
		repeat (12) @(posedge clk);
		#1;
		sys_rst = 1'h0;
		tk();
		t_reset_masks();
		t_causes();
		t_refused();
		t_error();
		t_raise();
		finish_test();
	end
endmodule // test_cpu_trap_exception_unit

bind cteu_trap_unit cteu_checker chk_u (.*);
